//--- fhd_asserts.sv
// Purpose: Port assertions for fhd_decoder.
// Assumes: One clock, sync active-low reset.
// Notes: Bound into every fhd_decoder.
`timescale 1ns/1ns
`default_nettype none
module fhd_asserts
  import fhd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] bus_addr,
  input wire logic bus_read_strobe_n,
  input wire logic bus_data_oe_n,
  input wire logic type_port_enable_n,
  input wire logic motor_a_on,
  input wire logic motor_b_on,
  input wire logic drive_a_select,
  input wire logic drive_b_select,
  input wire logic reduced_write,
  input wire logic [1:0] rate_code,
  input wire logic rate_clk_en,
  input wire logic seq_reset_n,
  input wire logic res_pop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_reset_clear: assert property (
    $rose(rstn) |-> !(motor_a_on || motor_b_on || seq_reset_n || |rate_code))
    else $error("not cleared");
  a_select_one: assert property (
    $past(rstn, 2) |-> drive_a_select != drive_b_select)
    else $error("select bad");
  a_reduced_rate: assert property (
    $past(rstn, 2) && $stable(rate_code)
    |-> reduced_write == (rate_code != FHD_RATE_500K))
    else $error("reduced bad");
  a_rsvd_quiet: assert property (
    (rate_code == FHD_RATE_RSVD)[*3] |-> !rate_clk_en)
    else $error("pulse at 11");
  a_pulse_gap: assert property (
    rate_clk_en |=> !rate_clk_en[*8])
    else $error("pulse gap");
  a_oe_cause: assert property (
    $fell(bus_data_oe_n) |-> !$past(bus_read_strobe_n, 2))
    else $error("oe no read");
  a_oe_release: assert property (
    bus_read_strobe_n[*6] |-> bus_data_oe_n)
    else $error("oe held");
  a_type_addr: assert property (
    !type_port_enable_n |-> $past(bus_addr, 2) == FHD_ADDR_TYPE_PORT)
    else $error("type addr");
  a_pop_read: assert property (
    res_pop |-> $rose(bus_data_oe_n))
    else $error("pop no read");
  c_pulse: cover property (rate_clk_en);
  c_type: cover property (!type_port_enable_n);
  c_pop: cover property (res_pop);
endmodule
bind fhd_decoder fhd_asserts u_chk (.*);
`default_nettype wire

//--- fhd_decoder.sv
// Purpose: Host register file and I/O decoder of a floppy disk controller.
// Assumes: Bus pins are asynchronous and pass two flip-flops first.
// Notes: Command bytes queue in a FIFO toward the sequencer.
//
// Overview of operation
// - Write-only drive control register, cleared by reset
// - Bits 5 and 4 run motors B, A
// - Bit 3 gates interrupt and DMA request
// - Bit 2 low holds controller in reset
// - Bit 0 selects drive A or B
// - Diagnostic read shows disk change in bit 7
// - Diagnostic address write loads rate code
// - Rate code sets bit clock divider
// - Status bit 7 means data port ready
// - Status bit 6 gives transfer direction
// - Status bit 5 flags programmed I/O mode
// - Status bit 4 flags command busy
// - Status bits 1, 0 flag drive seeks
// - Data port fronts command and result bytes
// - Fixed disk status reads with bit 7 set
// - Hard disk present disables fixed status
// - Group select picks primary or secondary addresses
// - Type port enable low on its read, in the primary group only
// - Reduced write current except at 500K
`timescale 1ns/1ns
`default_nettype none

module fhd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [WIDTH-1:0] odata_r, odata_nxt;
  logic ovalid_r, ovalid_nxt, push, load;

  always_comb begin
    in_ready = (wp_r - rp_r) + (AW+1)'(ovalid_r) != (AW+1)'(DEPTH);
    out_valid = ovalid_r;
    out_data = odata_r;
    push = in_valid && in_ready;
    load = (wp_r != rp_r) && (!ovalid_r || out_ready);
    wp_nxt = wp_r + (AW+1)'(push);
    rp_nxt = rp_r + (AW+1)'(load);
    ovalid_nxt = load || (ovalid_r && !out_ready);
    odata_nxt = load ? mem[rp_r[AW-1:0]] : odata_r;
    if (flush) begin
      wp_nxt = '0;
      rp_nxt = '0;
      ovalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      ovalid_r <= 1'b0;
      odata_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      ovalid_r <= ovalid_nxt;
      odata_r <= odata_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule

module fhd_decoder
  import fhd_pkg::*;
#(
  parameter int FIFO_DEPTH = FHD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  // Host I/O bus pins
  input wire logic [9:0] bus_addr,
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe_n,
  input wire logic bus_read_strobe_n,
  input wire logic bus_write_strobe_n,
  // Strap and drive pins
  input wire logic group_primary,
  input wire logic hard_disk_present_n,
  input wire logic disk_change,
  output logic type_port_enable_n,
  output logic motor_a_on,
  output logic motor_b_on,
  output logic drive_a_select,
  output logic drive_b_select,
  output logic reduced_write,
  output logic [1:0] rate_code,
  output logic rate_clk_en,
  // Sequencer side, same clock
  output logic seq_reset_n,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [7:0] cmd_data,
  input wire logic res_valid,
  output logic res_pop,
  input wire logic [7:0] res_data,
  input wire logic seq_dir_to_host,
  input wire logic seq_pio_mode,
  input wire logic seq_busy,
  input wire logic seq_seek_a,
  input wire logic seq_seek_b,
  input wire logic seq_irq_req,
  input wire logic seq_drq_req,
  output logic irq,
  output logic drq
);

  function automatic logic fhd_hit(input logic [9:0] a,
                                   input logic [9:0] prim,
                                   input logic grp);
    fhd_hit = a == (grp ? prim : (prim & FHD_SEC_MASK));
  endfunction

  function automatic logic [FHD_ACC_W-1:0] fhd_step(input logic [1:0] code);
    case (code)
      FHD_RATE_500K: fhd_step = FHD_STEP_500K;
      FHD_RATE_300K: fhd_step = FHD_STEP_300K;
      FHD_RATE_250K: fhd_step = FHD_STEP_250K;
      default: fhd_step = '0;
    endcase
  endfunction

  // Two-stage synchronisers for every pin input
  logic [9:0] addr_m, addr_s;
  logic [7:0] din_m, din_s;
  logic rd_m, rd_s, wr_m, wr_s;
  logic grp_m, grp_s, hdp_m, hdp_s, chg_m, chg_s;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_m <= '0;
      addr_s <= '0;
      din_m <= '0;
      din_s <= '0;
      rd_m <= 1'b1;
      rd_s <= 1'b1;
      wr_m <= 1'b1;
      wr_s <= 1'b1;
      grp_m <= 1'b1;
      grp_s <= 1'b1;
      hdp_m <= 1'b1;
      hdp_s <= 1'b1;
      chg_m <= 1'b0;
      chg_s <= 1'b0;
    end else begin
      addr_m <= bus_addr;
      addr_s <= addr_m;
      din_m <= bus_data_in;
      din_s <= din_m;
      rd_m <= bus_read_strobe_n;
      rd_s <= rd_m;
      wr_m <= bus_write_strobe_n;
      wr_s <= wr_m;
      grp_m <= group_primary;
      grp_s <= grp_m;
      hdp_m <= hard_disk_present_n;
      hdp_s <= hdp_m;
      chg_m <= disk_change;
      chg_s <= chg_m;
    end
  end

  // Address decode
  logic hit_doc, hit_msr, hit_data, hit_diag, hit_fixed, hit_type;
  always_comb begin
    hit_doc = fhd_hit(addr_s, FHD_ADDR_DOC, grp_s);
    hit_msr = fhd_hit(addr_s, FHD_ADDR_MSR, grp_s);
    hit_data = fhd_hit(addr_s, FHD_ADDR_DATA, grp_s);
    hit_diag = fhd_hit(addr_s, FHD_ADDR_DIAG, grp_s);
    hit_fixed = fhd_hit(addr_s, FHD_ADDR_FIXED, grp_s) && hdp_s;
    hit_type = grp_s && addr_s == FHD_ADDR_TYPE_PORT;
  end

  // Command FIFO
  logic fifo_in_valid, fifo_in_ready;
  logic [7:0] doc_r, doc_nxt;

  fhd_fifo #(
    .WIDTH(FHD_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk(clk),
    .rstn(rstn),
    .flush(!doc_r[FHD_DOC_RUN]),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(din_s),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(cmd_data)
  );

  // Main status assembly
  logic [7:0] msr;
  always_comb begin
    msr = 8'h00;
    msr[FHD_MSR_READY] = seq_dir_to_host ? res_valid : fifo_in_ready;
    msr[FHD_MSR_DIR] = seq_dir_to_host;
    msr[FHD_MSR_PIO] = seq_pio_mode;
    msr[FHD_MSR_BUSY] = seq_busy;
    msr[FHD_MSR_SEEK_B] = seq_seek_b;
    msr[FHD_MSR_SEEK_A] = seq_seek_a;
  end

  // Host bus access sequencing and register writes
  fhd_state_t st_r, st_nxt;
  logic [1:0] rate_r, rate_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic oe_n_r, oe_n_nxt, tpe_n_r, tpe_n_nxt;
  logic rd_data_r, rd_data_nxt, pop_r, pop_nxt;

  always_comb begin
    st_nxt = st_r;
    doc_nxt = doc_r;
    rate_nxt = rate_r;
    dout_nxt = dout_r;
    oe_n_nxt = oe_n_r;
    tpe_n_nxt = tpe_n_r;
    rd_data_nxt = rd_data_r;
    pop_nxt = 1'b0;
    fifo_in_valid = 1'b0;
    case (st_r)
      FHD_ST_IDLE: begin
        if (!rd_s) begin
          st_nxt = FHD_ST_READ;
          oe_n_nxt = 1'b0;
          rd_data_nxt = hit_data;
          tpe_n_nxt = !hit_type;
          dout_nxt = 8'h00;
          if (hit_msr) begin
            dout_nxt = msr;
          end else if (hit_data) begin
            dout_nxt = res_data;
          end else if (hit_diag) begin
            dout_nxt[FHD_DIAG_CHANGE] = chg_s;
          end else if (hit_fixed) begin
            dout_nxt = FHD_FIXED_STATUS;
          end else begin
            oe_n_nxt = 1'b1;
          end
        end else if (!wr_s) begin
          st_nxt = FHD_ST_WRITE;
          if (hit_doc) begin
            doc_nxt = din_s & FHD_DOC_WMASK;
          end
          if (hit_diag) begin
            rate_nxt = din_s[1:0];
          end
          fifo_in_valid = hit_data && doc_r[FHD_DOC_RUN];
        end
      end
      FHD_ST_READ: begin
        if (rd_s) begin
          st_nxt = FHD_ST_IDLE;
          oe_n_nxt = 1'b1;
          tpe_n_nxt = 1'b1;
          pop_nxt = rd_data_r && seq_dir_to_host && res_valid;
        end
      end
      FHD_ST_WRITE: begin
        if (wr_s) begin
          st_nxt = FHD_ST_IDLE;
        end
      end
      default: begin
        st_nxt = FHD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= FHD_ST_IDLE;
      doc_r <= FHD_DOC_RESET;
      rate_r <= FHD_RATE_RESET;
      dout_r <= 8'h00;
      oe_n_r <= 1'b1;
      tpe_n_r <= 1'b1;
      rd_data_r <= 1'b0;
      pop_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      doc_r <= doc_nxt;
      rate_r <= rate_nxt;
      dout_r <= dout_nxt;
      oe_n_r <= oe_n_nxt;
      tpe_n_r <= tpe_n_nxt;
      rd_data_r <= rd_data_nxt;
      pop_r <= pop_nxt;
    end
  end

  // Drive control, request gating and bit clock
  logic [FHD_ACC_W-1:0] acc_r, acc_nxt;
  logic [7:0] drv_r, drv_nxt;
  logic clk_en_r, clk_en_nxt;
  logic [FHD_ACC_W:0] acc_sum;

  always_comb begin
    acc_sum = {1'b0, acc_r} + {1'b0, fhd_step(rate_r)};
    acc_nxt = acc_sum[FHD_ACC_W-1:0];
    clk_en_nxt = acc_sum[FHD_ACC_W];
    drv_nxt = 8'h00;
    drv_nxt[0] = doc_r[FHD_DOC_MOTOR_A];
    drv_nxt[1] = doc_r[FHD_DOC_MOTOR_B];
    drv_nxt[2] = !doc_r[FHD_DOC_DRIVE_SEL];
    drv_nxt[3] = doc_r[FHD_DOC_DRIVE_SEL];
    drv_nxt[4] = rate_r != FHD_RATE_500K;
    drv_nxt[5] = doc_r[FHD_DOC_RUN];
    drv_nxt[6] = doc_r[FHD_DOC_IRQ_DMA_EN] && seq_irq_req;
    drv_nxt[7] = doc_r[FHD_DOC_IRQ_DMA_EN] && seq_drq_req;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_r <= '0;
      drv_r <= 8'h00;
      clk_en_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      drv_r <= drv_nxt;
      clk_en_r <= clk_en_nxt;
    end
  end

  assign bus_data_out = dout_r;
  assign bus_data_oe_n = oe_n_r;
  assign type_port_enable_n = tpe_n_r;
  assign motor_a_on = drv_r[0];
  assign motor_b_on = drv_r[1];
  assign drive_a_select = drv_r[2];
  assign drive_b_select = drv_r[3];
  assign reduced_write = drv_r[4];
  assign seq_reset_n = drv_r[5];
  assign irq = drv_r[6];
  assign drq = drv_r[7];
  assign rate_code = rate_r;
  assign rate_clk_en = clk_en_r;
  assign res_pop = pop_r;

endmodule

`default_nettype wire

//--- fhd_decoder_test.sv
// Purpose: Self-checking bench for fhd_decoder.
// Assumes: fhd_host drives the I/O bus.
// Notes: Seeded xorshift picks values.
`timescale 1ns/1ns
`default_nettype none
module fhd_decoder_test;
  import fhd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] bus_addr;
  logic [7:0] bus_data_in, bus_data_out, cmd_data, res_data = 8'h00;
  logic bus_data_oe_n, bus_read_strobe_n, bus_write_strobe_n, irq, drq;
  logic type_port_enable_n, motor_a_on, motor_b_on, drive_a_select;
  logic drive_b_select, reduced_write, rate_clk_en, seq_reset_n, res_pop;
  logic cmd_valid, cmd_ready = 1'b0, res_valid = 1'b0, disk_change = 1'b0;
  logic group_primary = 1'b1, hard_disk_present_n = 1'b1, tp_seen = 1'b0;
  logic seq_dir_to_host = 1'b0, seq_pio_mode = 1'b0, seq_busy = 1'b0;
  logic seq_seek_a = 1'b0, seq_seek_b = 1'b0;
  logic seq_irq_req = 1'b1, seq_drq_req = 1'b1;
  logic [1:0] rate_code;
  logic [31:0] seed = 32'h00000025;
  int miscompares = 0;
  int comparisons = 0;
  int pops = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (!type_port_enable_n) tp_seen <= 1'b1;
  always @(posedge clk) if (res_pop === 1'b1) pops <= pops + 1;
  fhd_decoder dut (.*);
  fhd_host host (.*);
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [8:0] exp_out(logic [7:0] c, logic [1:0] r);
    return {1'b0, c[5], c[4], c[2], c[0], ~c[0], r != 2'h0, r};
  endfunction
  function automatic logic [8:0] outs();
    return {1'b0, motor_b_on, motor_a_on, seq_reset_n, drive_b_select,
      drive_a_select, reduced_write, rate_code};
  endfunction
  function automatic logic [9:0] ad(logic [9:0] a, int g);
    return (g != 0) ? (a & FHD_SEC_MASK) : a;
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [8:0] e);
    logic [7:0] q;
    logic drv;
    host.cyc(a, 8'h00, 1'b1, q, drv);
    chk({drv, drv ? q : 8'h00}, e);
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic drv;
    host.cyc(a, d, 1'b0, q, drv);
  endtask
  initial begin
    logic [7:0] v;
    logic [7:0] c;
    logic [7:0] q[$];
    logic x;
    int n;
    static int e[4] = '{80, 48, 40, 0};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(outs(), exp_out(8'h00, 2'h0));
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 8'hFF : rnd();
      {seq_irq_req, seq_drq_req} <= c[7:6];
      wr_reg(FHD_ADDR_DOC, c);
      chk(outs(), exp_out(c, 2'h0));
      chk({7'h00, irq, drq}, {7'h00, c[3] & c[7], c[3] & c[6]});
    end
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      wr_reg(FHD_ADDR_DIAG, {v[7:2], 2'(k)});
      chk(outs(), exp_out(c, 2'(k)));
      n = 0;
      repeat (1000) begin
        @(posedge clk);
        n += int'(rate_clk_en);
      end
      chk({8'h00, n >= e[k] - 1 && n <= e[k] + 1}, 9'h001);
    end
    wr_reg(FHD_ADDR_DOC, 8'h04);
    v = rnd();
    seq_dir_to_host <= 1'b1;
    seq_pio_mode <= v[5];
    seq_busy <= v[4];
    seq_seek_b <= v[1];
    seq_seek_a <= v[0];
    res_valid <= 1'b1;
    res_data <= v;
    rd_chk(FHD_ADDR_MSR, {3'h7, v[5:4], 2'h0, v[1:0]});
    rd_chk(FHD_ADDR_DATA, {1'b1, v});
    chk({8'h00, pops == 1}, 9'h001);
    seq_dir_to_host <= 1'b0;
    res_valid <= 1'b0;
    for (int i = 0; i < 33; i++) begin
      c = rnd();
      if (i < FHD_FIFO_DEPTH) q.push_back(c);
      wr_reg(FHD_ADDR_DATA, c);
    end
    rd_chk(FHD_ADDR_MSR, {3'h4, v[5:4], 2'h0, v[1:0]});
    cmd_ready <= 1'b1;
    repeat (64) begin
      @(posedge clk);
      if (cmd_valid === 1'b1) chk({1'b0, cmd_data}, {1'b0, q.pop_front()});
    end
    chk({cmd_valid, 8'(q.size())}, 9'h000);
    for (int g = 0; g < 2; g++) begin
      group_primary <= (g == 0);
      disk_change <= (g == 0);
      hard_disk_present_n <= 1'b1;
      rd_chk(ad(FHD_ADDR_DIAG, g), {1'b1, g == 0, 7'h00});
      rd_chk(ad(FHD_ADDR_FIXED, g), {1'b1, FHD_FIXED_STATUS});
      rd_chk(ad(FHD_ADDR_DOC, g), 9'h000);
      rd_chk(ad(10'h3F3, g), 9'h000);
      rd_chk(ad(FHD_ADDR_MSR, 1 - g), 9'h000);
      hard_disk_present_n <= 1'b0;
      rd_chk(ad(FHD_ADDR_FIXED, g), 9'h000);
    end
    group_primary <= 1'b1;
    host.cyc(FHD_ADDR_TYPE_PORT, 8'h00, 1'b1, v, x);
    chk({6'h00, tp_seen, x, type_port_enable_n}, 9'h005);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(outs(), exp_out(8'h00, 2'h0));
    give_verdict();
  end
endmodule
`default_nettype wire

//--- fhd_host.sv
// Purpose: Host processor model on the I/O bus.
// Assumes: Signals change just after clk rises.
// Notes: Undriven data lines show inverted value.
`timescale 1ns/1ns
`default_nettype none
module fhd_host (
  input wire logic clk,
  input wire logic bus_data_oe_n,
  input wire logic [7:0] bus_data_out,
  output logic [9:0] bus_addr,
  output logic [7:0] bus_data_in,
  output logic bus_read_strobe_n,
  output logic bus_write_strobe_n
);
  initial begin
    bus_addr = 10'h000;
    bus_data_in = 8'h00;
    bus_read_strobe_n = 1'b1;
    bus_write_strobe_n = 1'b1;
  end
  task automatic cyc(input logic [9:0] a, input logic [7:0] d,
      input logic rd, output logic [7:0] q, output logic drv);
    drv = 1'b0;
    q = 8'h00;
    @(posedge clk);
    bus_addr <= a;
    bus_data_in <= rd ? ~bus_data_in : d;
    repeat (3) @(posedge clk);
    bus_read_strobe_n <= !rd;
    bus_write_strobe_n <= rd;
    repeat (8) begin
      @(posedge clk);
      if (bus_data_oe_n === 1'b0) begin
        drv = 1'b1;
        q = bus_data_out;
      end
    end
    bus_read_strobe_n <= 1'b1;
    bus_write_strobe_n <= 1'b1;
    bus_data_in <= ~d;
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- fhd_pkg.sv
// Purpose: Constants and types for the floppy host register decoder.
// Assumes: 10-bit I/O addresses, 8-bit data, 100 MHz system clock.
// Notes: Secondary-group addresses are primary ones with address bit 7 low.
package fhd_pkg;

  // Register addresses in the primary group
  localparam logic [9:0] FHD_ADDR_TYPE_PORT = 10'h3F1;
  localparam logic [9:0] FHD_ADDR_DOC = 10'h3F2;
  localparam logic [9:0] FHD_ADDR_MSR = 10'h3F4;
  localparam logic [9:0] FHD_ADDR_DATA = 10'h3F5;
  localparam logic [9:0] FHD_ADDR_DIAG = 10'h3F7;
  localparam logic [9:0] FHD_ADDR_FIXED = 10'h1F7;
  localparam logic [9:0] FHD_SEC_MASK = 10'h37F;

  // Drive output control fields
  localparam int FHD_DOC_MOTOR_B = 5;
  localparam int FHD_DOC_MOTOR_A = 4;
  localparam int FHD_DOC_IRQ_DMA_EN = 3;
  localparam int FHD_DOC_RUN = 2;
  localparam int FHD_DOC_DRIVE_SEL = 0;
  localparam logic [7:0] FHD_DOC_WMASK = 8'h3D;
  localparam logic [7:0] FHD_DOC_RESET = 8'h00;

  // Main status fields
  localparam int FHD_MSR_READY = 7;
  localparam int FHD_MSR_DIR = 6;
  localparam int FHD_MSR_PIO = 5;
  localparam int FHD_MSR_BUSY = 4;
  localparam int FHD_MSR_SEEK_B = 1;
  localparam int FHD_MSR_SEEK_A = 0;

  // Diagnostic input and fixed disk status
  localparam int FHD_DIAG_CHANGE = 7;
  localparam logic [7:0] FHD_FIXED_STATUS = 8'h80;

  // Transfer rate codes and reset value
  localparam logic [1:0] FHD_RATE_500K = 2'h0;
  localparam logic [1:0] FHD_RATE_300K = 2'h1;
  localparam logic [1:0] FHD_RATE_250K = 2'h2;
  localparam logic [1:0] FHD_RATE_RSVD = 2'h3;
  localparam logic [1:0] FHD_RATE_RESET = FHD_RATE_500K;

  // Bit clock generation by phase accumulator
  localparam int FHD_CLK_KHZ = 100000;
  localparam int FHD_F500_KHZ = 8000;
  localparam int FHD_F300_KHZ = 4800;
  localparam int FHD_F250_KHZ = 4000;
  localparam int FHD_ACC_W = 16;
  localparam logic [FHD_ACC_W-1:0] FHD_STEP_500K =
    FHD_ACC_W'((FHD_F500_KHZ * 65536 + FHD_CLK_KHZ / 2) / FHD_CLK_KHZ);
  localparam logic [FHD_ACC_W-1:0] FHD_STEP_300K =
    FHD_ACC_W'((FHD_F300_KHZ * 65536 + FHD_CLK_KHZ / 2) / FHD_CLK_KHZ);
  localparam logic [FHD_ACC_W-1:0] FHD_STEP_250K =
    FHD_ACC_W'((FHD_F250_KHZ * 65536 + FHD_CLK_KHZ / 2) / FHD_CLK_KHZ);

  // Command byte buffer
  localparam int FHD_FIFO_WIDTH = 8;
  localparam int FHD_FIFO_DEPTH = 32;

  // Host bus access phases, Gray along idle-read and idle-write
  typedef enum logic [1:0] {
    FHD_ST_IDLE = 2'b00,
    FHD_ST_READ = 2'b01,
    FHD_ST_WRITE = 2'b10
  } fhd_state_t;

endpackage
